// ===== hdl/sbrc_pkg.sv
package sbrc_pkg;
    localparam int ADDR_W = 10;
    localparam logic [9:0] RESET_ADDR = 10'h000;
    localparam logic [9:0] DISCONNECT_ADDR = 10'h3fe;
    localparam logic [9:0] TEST_SYNC_ADDR = 10'h3ff;
    localparam logic [9:0] BOARD_ADDR_RST = 10'h001;
    localparam int ACK_BITS_DFLT = 10;
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam int CTRL_ADDR_LSB = 0;
    localparam int STAT_CONN_LSB = 0;
    localparam int STAT_RX_LSB = 4;
    localparam int STAT_TAP_LSB = 8;
    localparam int STAT_CON_BIT = 16;
    localparam int STAT_BYP_BIT = 17;
    localparam int STAT_TRST_BIT = 18;

    typedef enum logic [3:0] {
        TAP_TLR = 4'h0, TAP_RTI = 4'h1, TAP_SDR = 4'h2, TAP_CDR = 4'h3,
        TAP_SHDR = 4'h4, TAP_E1DR = 4'h5, TAP_PDR = 4'h6, TAP_E2DR = 4'h7,
        TAP_UDR = 4'h8, TAP_SIR = 4'h9, TAP_CIR = 4'ha, TAP_SHIR = 4'hb,
        TAP_E1IR = 4'hc, TAP_PIR = 4'hd, TAP_E2IR = 4'he, TAP_UIR = 4'hf
    } sbrc_tap_e;

    typedef enum logic [2:0] {
        CONN_RESET = 3'h0, CONN_OFF = 3'h1, CONN_ON = 3'h2,
        CONN_MCAST = 3'h3, CONN_HARD = 3'h4
    } sbrc_conn_e;

    typedef enum logic [1:0] {
        RX_IDLE = 2'h0, RX_ADDR = 2'h1, RX_STOP = 2'h2, RX_ACK = 2'h3
    } sbrc_rx_e;

    typedef struct packed {
        logic primary_test_clock;
        logic psi;
        logic pms;
        logic primary_test_reset_n_n;
        logic byp_n;
        logic ssi;
    } sbrc_pins_s;

    typedef struct packed {
        logic con_n;
        logic pso;
        logic pso_oe;
        logic sso;
        logic sso_oe;
        logic sms;
        logic secondary_test_reset_n_n;
        logic stck;
    } sbrc_outs_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } sbrc_apb_s;

    typedef struct packed {
        sbrc_pins_s s1;
        sbrc_pins_s s2;
        logic primary_test_clock_prev;
        sbrc_tap_e tap;
        sbrc_rx_e rx;
        logic [3:0] cnt;
        logic [9:0] shf;
        logic ms_ref;
        sbrc_conn_e conn;
        logic [9:0] board_addr;
        sbrc_outs_s o;
        sbrc_apb_s apb;
    } sbrc_state_s;
endpackage

// ===== hdl/sbrc_top.sv
// Functional notes
// RULE1: low bypass forces bypass status always
// RULE2: bypass drives connect indicator low
// RULE3: bypass crosses serial data both ways
// RULE4: bypass passes mode-select, high under reset
// RULE5: bypass holds receiver in power-up state
// RULE6: bypass release restores last connect status
// RULE7: bypass release re-enables receiver
// RULE8: test reset forwarded and resets block
// RULE9: reset without bypass: indicator high, floats
// RULE10: reset with bypass: bypass-plus-reset status
// RULE11: secondary mode-select high during test reset
// RULE12: no protocol accepted during test reset
// RULE13: indicator low on match or test sync
// RULE14: indicator high otherwise and during acknowledge
// RULE15: master keeps acknowledge inputs harmless
// RULE16: mode-select change in protocol is hard error
// RULE17: match then acknowledge gives on status
// RULE18: off status floats, holds mode-select
// RULE19: global reset, disconnect, test-sync addresses
// RULE20: test sync while paused gives multicast
// RULE21: last result held, cleared by test reset
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

module sbrc_top #(
    parameter int ACK_BITS = sbrc_pkg::ACK_BITS_DFLT
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // primary port
    input wire logic primary_test_clock_i,
    input wire logic primary_serial_in_i,
    input wire logic primary_mode_select_i,
    input wire logic primary_test_reset_n_i,
    output logic primary_serial_out_o,
    output logic primary_serial_out_oe_o,
    // secondary port
    input wire logic secondary_serial_in_i,
    output logic secondary_serial_out_o,
    output logic secondary_serial_out_oe_o,
    output logic secondary_mode_select_o,
    output logic secondary_test_reset_n_o,
    output logic secondary_test_clock_o,
    // control pins
    input wire logic protocol_bypass_n_i,
    output logic connect_indicator_n_o,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o
);
    if (ACK_BITS < 1 || ACK_BITS > 15) begin : g_bad_ack_bits
        $error("ACK_BITS must lie in 1..15");
    end

    localparam logic [3:0] ACK_LAST = 4'(ACK_BITS - 1);

    sbrc_pkg::sbrc_state_s q;
    sbrc_pkg::sbrc_state_s d;

    function automatic sbrc_pkg::sbrc_tap_e tap_next(input sbrc_pkg::sbrc_tap_e s,
                                                     input logic tms);
        unique case (s)
            sbrc_pkg::TAP_TLR: tap_next = tms ? sbrc_pkg::TAP_TLR : sbrc_pkg::TAP_RTI;
            sbrc_pkg::TAP_RTI: tap_next = tms ? sbrc_pkg::TAP_SDR : sbrc_pkg::TAP_RTI;
            sbrc_pkg::TAP_SDR: tap_next = tms ? sbrc_pkg::TAP_SIR : sbrc_pkg::TAP_CDR;
            sbrc_pkg::TAP_CDR: tap_next = tms ? sbrc_pkg::TAP_E1DR : sbrc_pkg::TAP_SHDR;
            sbrc_pkg::TAP_SHDR: tap_next = tms ? sbrc_pkg::TAP_E1DR : sbrc_pkg::TAP_SHDR;
            sbrc_pkg::TAP_E1DR: tap_next = tms ? sbrc_pkg::TAP_UDR : sbrc_pkg::TAP_PDR;
            sbrc_pkg::TAP_PDR: tap_next = tms ? sbrc_pkg::TAP_E2DR : sbrc_pkg::TAP_PDR;
            sbrc_pkg::TAP_E2DR: tap_next = tms ? sbrc_pkg::TAP_UDR : sbrc_pkg::TAP_SHDR;
            sbrc_pkg::TAP_UDR: tap_next = tms ? sbrc_pkg::TAP_SDR : sbrc_pkg::TAP_RTI;
            sbrc_pkg::TAP_SIR: tap_next = tms ? sbrc_pkg::TAP_TLR : sbrc_pkg::TAP_CIR;
            sbrc_pkg::TAP_CIR: tap_next = tms ? sbrc_pkg::TAP_E1IR : sbrc_pkg::TAP_SHIR;
            sbrc_pkg::TAP_SHIR: tap_next = tms ? sbrc_pkg::TAP_E1IR : sbrc_pkg::TAP_SHIR;
            sbrc_pkg::TAP_E1IR: tap_next = tms ? sbrc_pkg::TAP_UIR : sbrc_pkg::TAP_PIR;
            sbrc_pkg::TAP_PIR: tap_next = tms ? sbrc_pkg::TAP_E2IR : sbrc_pkg::TAP_PIR;
            sbrc_pkg::TAP_E2IR: tap_next = tms ? sbrc_pkg::TAP_UIR : sbrc_pkg::TAP_SHIR;
            sbrc_pkg::TAP_UIR: tap_next = tms ? sbrc_pkg::TAP_SDR : sbrc_pkg::TAP_RTI;
        endcase
    endfunction

    function automatic logic tap_paused(input sbrc_pkg::sbrc_tap_e s);
        tap_paused = (s == sbrc_pkg::TAP_PDR) || (s == sbrc_pkg::TAP_PIR);
    endfunction

    logic primary_test_clock_rise;
    logic protocol_bypass_n;
    logic trst_lo;
    logic rx_en;
    logic ms_err;
    logic acc;

    always_comb begin
        d = q;
        d.s1 = '{primary_test_clock: primary_test_clock_i, psi: primary_serial_in_i,
                 pms: primary_mode_select_i, primary_test_reset_n_n: primary_test_reset_n_i,
                 byp_n: protocol_bypass_n_i, ssi: secondary_serial_in_i};
        d.s2 = q.s1;
        d.primary_test_clock_prev = q.s2.primary_test_clock;
        primary_test_clock_rise = q.s2.primary_test_clock && !q.primary_test_clock_prev;
        protocol_bypass_n = !q.s2.byp_n;
        trst_lo = !q.s2.primary_test_reset_n_n;
        // shadow protocols are seen only in the four stable receive states
        rx_en = !protocol_bypass_n && !trst_lo &&
                (q.tap == sbrc_pkg::TAP_TLR || q.tap == sbrc_pkg::TAP_RTI ||
                 tap_paused(q.tap)); // RULE7 RULE12
        ms_err = (q.rx != sbrc_pkg::RX_IDLE) && (q.s2.pms != q.ms_ref);

        // shadow-protocol receiver
        if (trst_lo) begin
            d.rx = sbrc_pkg::RX_IDLE; // RULE12
            d.cnt = 4'h0;
            d.tap = sbrc_pkg::TAP_TLR;
            d.conn = sbrc_pkg::CONN_RESET; // RULE21
        end else if (protocol_bypass_n) begin
            d.rx = sbrc_pkg::RX_IDLE; // RULE5
            d.cnt = 4'h0;
            d.tap = sbrc_pkg::TAP_TLR; // RULE5
        end else if (primary_test_clock_rise) begin
            d.tap = tap_next(q.tap, q.s2.pms);
            if (ms_err) begin
                d.conn = sbrc_pkg::CONN_HARD; // RULE16
                d.rx = sbrc_pkg::RX_IDLE;
            end else begin
                unique case (q.rx)
                    sbrc_pkg::RX_IDLE: begin
                        if (rx_en && q.s2.psi) begin
                            d.rx = sbrc_pkg::RX_ADDR;
                            d.cnt = 4'h0;
                            d.ms_ref = q.s2.pms;
                            d.tap = q.tap;
                        end
                    end
                    sbrc_pkg::RX_ADDR: begin
                        d.tap = q.tap;
                        d.shf = {q.s2.psi, q.shf[9:1]};
                        d.cnt = q.cnt + 4'h1;
                        if (q.cnt == 4'(sbrc_pkg::ADDR_W - 1)) begin
                            d.rx = sbrc_pkg::RX_STOP;
                        end
                    end
                    sbrc_pkg::RX_STOP: begin
                        d.tap = q.tap;
                        d.rx = sbrc_pkg::RX_IDLE;
                        d.cnt = 4'h0;
                        // a high stop bit is a soft error: the last result stands
                        if (!q.s2.psi) begin
                            if (q.shf == sbrc_pkg::RESET_ADDR) begin
                                d.conn = sbrc_pkg::CONN_RESET; // RULE19
                            end else if (q.shf == sbrc_pkg::DISCONNECT_ADDR) begin
                                d.conn = sbrc_pkg::CONN_OFF; // RULE19
                            end else if (q.shf == sbrc_pkg::TEST_SYNC_ADDR) begin
                                d.conn = tap_paused(q.tap) ? sbrc_pkg::CONN_MCAST
                                                           : sbrc_pkg::CONN_OFF; // RULE20
                            end else if (q.shf == q.board_addr) begin
                                d.rx = sbrc_pkg::RX_ACK; // RULE17
                            end else begin
                                d.conn = sbrc_pkg::CONN_OFF;
                            end
                        end
                    end
                    sbrc_pkg::RX_ACK: begin
                        d.tap = q.tap;
                        d.shf = {q.shf[0], q.shf[9:1]};
                        d.cnt = q.cnt + 4'h1;
                        if (q.cnt == ACK_LAST) begin
                            d.conn = sbrc_pkg::CONN_ON; // RULE17
                            d.rx = sbrc_pkg::RX_IDLE;
                            d.cnt = 4'h0;
                        end
                    end
                endcase
            end
        end

        // pin routing
        d.o.secondary_test_reset_n_n = q.s2.primary_test_reset_n_n; // RULE8
        d.o.stck = q.s2.primary_test_clock;
        d.o.pso = 1'b0;
        d.o.pso_oe = 1'b0;
        d.o.sso = 1'b0;
        d.o.sso_oe = 1'b0;
        d.o.con_n = 1'b1; // RULE14
        if (protocol_bypass_n) begin
            d.o.sso = q.s2.psi; // RULE1 RULE3 RULE10
            d.o.sso_oe = 1'b1;
            d.o.pso = q.s2.ssi; // RULE3
            d.o.pso_oe = 1'b1;
            d.o.sms = trst_lo ? 1'b1 : q.s2.pms; // RULE4 RULE11
            d.o.con_n = 1'b0; // RULE2
        end else if (trst_lo) begin
            d.o.sms = 1'b1; // RULE9 RULE11
        end else if (q.rx == sbrc_pkg::RX_ACK) begin
            d.o.pso = q.shf[0]; // RULE14
            d.o.pso_oe = 1'b1;
        end else begin
            // connect status resumes from the stored result when bypass lifts
            unique case (q.conn) // RULE6
                sbrc_pkg::CONN_ON: begin
                    d.o.sso = q.s2.psi;
                    d.o.sso_oe = 1'b1;
                    d.o.pso = q.s2.ssi;
                    d.o.pso_oe = 1'b1;
                    d.o.sms = q.s2.pms;
                    d.o.con_n = 1'b0; // RULE13
                end
                sbrc_pkg::CONN_MCAST: begin
                    d.o.sso = q.s2.psi; // RULE20
                    d.o.sso_oe = 1'b1;
                    d.o.sms = q.s2.pms;
                    d.o.con_n = 1'b0; // RULE13
                end
                sbrc_pkg::CONN_RESET: begin
                    d.o.sms = 1'b1;
                end
                sbrc_pkg::CONN_OFF, sbrc_pkg::CONN_HARD: begin
                    d.o.sms = q.o.sms; // RULE18
                end
                default: begin
                    d.o.sms = q.o.sms;
                end
            endcase
        end

        // apb slave: one wait state, answer registered
        acc = psel_i && penable_i;
        d.apb.pready = acc && !q.apb.pready;
        d.apb.pslverr = 1'b0;
        d.apb.prdata = 32'h0000_0000;
        if (acc && !q.apb.pready) begin
            if (paddr_i == sbrc_pkg::REG_CTRL) begin
                d.apb.prdata[sbrc_pkg::CTRL_ADDR_LSB +: 10] = q.board_addr;
            end else if (paddr_i == sbrc_pkg::REG_STATUS) begin
                d.apb.prdata[sbrc_pkg::STAT_CONN_LSB +: 3] = q.conn;
                d.apb.prdata[sbrc_pkg::STAT_RX_LSB +: 2] = q.rx;
                d.apb.prdata[sbrc_pkg::STAT_TAP_LSB +: 4] = q.tap;
                d.apb.prdata[sbrc_pkg::STAT_CON_BIT] = q.o.con_n;
                d.apb.prdata[sbrc_pkg::STAT_BYP_BIT] = protocol_bypass_n;
                d.apb.prdata[sbrc_pkg::STAT_TRST_BIT] = trst_lo;
            end else begin
                d.apb.pslverr = 1'b1;
            end
        end
        if (acc && q.apb.pready && pwrite_i && paddr_i == sbrc_pkg::REG_CTRL) begin
            d.board_addr = pwdata_i[sbrc_pkg::CTRL_ADDR_LSB +: 10];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.s1 <= 6'h06;
            q.s2 <= 6'h06;
            q.conn <= sbrc_pkg::CONN_RESET;
            q.board_addr <= sbrc_pkg::BOARD_ADDR_RST;
            q.o.con_n <= 1'b1;
            q.o.sms <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign primary_serial_out_o = q.o.pso;
    assign primary_serial_out_oe_o = q.o.pso_oe;
    assign secondary_serial_out_o = q.o.sso;
    assign secondary_serial_out_oe_o = q.o.sso_oe;
    assign secondary_mode_select_o = q.o.sms;
    assign secondary_test_reset_n_o = q.o.secondary_test_reset_n_n;
    assign secondary_test_clock_o = q.o.stck;
    assign connect_indicator_n_o = q.o.con_n;
    assign pready_o = q.apb.pready;
    assign prdata_o = q.apb.prdata;
    assign pslverr_o = q.apb.pslverr;
endmodule

`default_nettype wire

// ===== dv/sbrc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sbrc_properties #(
    parameter int ACK_BITS = 10
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // inputs
    input wire logic primary_serial_in_i,
    input wire logic primary_mode_select_i,
    input wire logic primary_test_reset_n_i,
    input wire logic secondary_serial_in_i,
    input wire logic protocol_bypass_n_i,
    // outputs
    input wire logic primary_serial_out_o,
    input wire logic primary_serial_out_oe_o,
    input wire logic secondary_serial_out_o,
    input wire logic secondary_serial_out_oe_o,
    input wire logic secondary_mode_select_o,
    input wire logic secondary_test_reset_n_o,
    input wire logic connect_indicator_n_o
);
    logic run_ok;
    logic byp_run;
    logic off_st;
    assign run_ok = protocol_bypass_n_i && primary_test_reset_n_i;
    assign byp_run = !protocol_bypass_n_i && primary_test_reset_n_i;
    assign off_st = connect_indicator_n_o && !primary_serial_out_oe_o && !secondary_serial_out_oe_o;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    byp_con_a: assert property ((!protocol_bypass_n_i)[*5] |-> !connect_indicator_n_o)
        else $error("indicator high in bypass");
    byp_data_a: assert property (byp_run[*5] |-> secondary_serial_out_oe_o
        && primary_serial_out_oe_o && secondary_serial_out_o == $past(primary_serial_in_i, 3)
        && primary_serial_out_o == $past(secondary_serial_in_i, 3))
        else $error("bypass data path wrong");
    byp_ms_a: assert property (byp_run[*5] |-> secondary_mode_select_o == $past(primary_mode_select_i, 3))
        else $error("bypass mode select wrong");
    trst_ms_a: assert property ((!primary_test_reset_n_i)[*5] |-> secondary_mode_select_o)
        else $error("mode select low in test reset");
    trst_fwd_a: assert property ((!primary_test_reset_n_i)[*5] |-> !secondary_test_reset_n_o)
        else $error("test reset not forwarded");
    trst_rel_a: assert property (primary_test_reset_n_i[*5] |-> secondary_test_reset_n_o)
        else $error("test reset release not forwarded");
    trst_float_a: assert property ((protocol_bypass_n_i && !primary_test_reset_n_i)[*5] |-> off_st)
        else $error("test reset status wrong");
    ack_con_a: assert property (run_ok[*5] ##0 (primary_serial_out_oe_o && !secondary_serial_out_oe_o)
        |-> connect_indicator_n_o)
        else $error("indicator low during acknowledge");
    con_drive_a: assert property (run_ok[*5] ##0 !connect_indicator_n_o |-> secondary_serial_out_oe_o)
        else $error("indicator low with secondary idle");
    off_hold_a: assert property (run_ok[*5] ##0 off_st[*2] |-> !$fell(secondary_mode_select_o))
        else $error("mode select dropped while off");
endmodule
bind sbrc_top sbrc_properties #(.ACK_BITS(ACK_BITS)) u_props (
    .clk_i(clk_i), .rst_i(rst_i), .primary_serial_in_i(primary_serial_in_i),
    .primary_mode_select_i(primary_mode_select_i), .primary_test_reset_n_i(primary_test_reset_n_i),
    .secondary_serial_in_i(secondary_serial_in_i), .protocol_bypass_n_i(protocol_bypass_n_i),
    .primary_serial_out_o(primary_serial_out_o), .primary_serial_out_oe_o(primary_serial_out_oe_o),
    .secondary_serial_out_o(secondary_serial_out_o),
    .secondary_serial_out_oe_o(secondary_serial_out_oe_o),
    .secondary_mode_select_o(secondary_mode_select_o),
    .secondary_test_reset_n_o(secondary_test_reset_n_o), .connect_indicator_n_o(connect_indicator_n_o)
);
`default_nettype wire

// ===== dv/sbrc_scan_chain.sv
`timescale 1ns/1ps
`default_nettype none
module sbrc_scan_chain (
    // secondary port of the block
    input wire logic stck_i,
    input wire logic sdi_i,
    input wire logic sdi_oe_i,
    input wire logic secondary_test_reset_n_n_i,
    // chain output
    output logic sdo_o
);
    logic bit_q;
    // an undriven input is not trusted: the stored bit flips instead
    always_ff @(posedge stck_i or negedge secondary_test_reset_n_n_i) begin
        if (!secondary_test_reset_n_n_i) begin
            bit_q <= 1'b0;
        end else begin
            bit_q <= sdi_oe_i ? sdi_i : !bit_q;
        end
    end
    assign sdo_o = bit_q;
endmodule
`default_nettype wire

// ===== dv/scan_port_bypass_reset_connect_tb.sv
`timescale 1ns/1ps
`default_nettype none
module scan_port_bypass_reset_connect_tb;
    localparam int ACK = 4;
    localparam logic [9:0] BOARD = 10'h155;
    localparam logic [9:0] SEQ_A [7] = '{BOARD, 10'h3fe, BOARD, 10'h2aa, 10'h3ff, BOARD, 10'h000};
    localparam logic [2:0] SEQ_C [7] = '{3'h2, 3'h1, 3'h2, 3'h1, 3'h1, 3'h2, 3'h0};
    logic clk_i, rst_i, primary_test_clock, psi, pms, primary_test_reset_n_n, byp_n, ssi, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, pso, pso_oe, sso, sso_oe, sms, secondary_test_reset_n_n, stck, con_n, err;
    int n_fail, tests_run;
    sbrc_top #(.ACK_BITS(ACK)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .primary_test_clock_i(primary_test_clock), .primary_serial_in_i(psi),
        .primary_mode_select_i(pms), .primary_test_reset_n_i(primary_test_reset_n_n), .primary_serial_out_o(pso),
        .primary_serial_out_oe_o(pso_oe), .secondary_serial_in_i(ssi), .secondary_serial_out_o(sso),
        .secondary_serial_out_oe_o(sso_oe), .secondary_mode_select_o(sms),
        .secondary_test_reset_n_o(secondary_test_reset_n_n), .secondary_test_clock_o(stck),
        .protocol_bypass_n_i(byp_n), .connect_indicator_n_o(con_n), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr)
    );
    sbrc_scan_chain u_chain (.stck_i(stck), .sdi_i(sso), .sdi_oe_i(sso_oe), .secondary_test_reset_n_n_i(secondary_test_reset_n_n),
        .sdo_o(ssi));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int i;
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_i);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk_i);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            n_fail++;
            wrap_up();
        end
    endtask
    // one link clock period, data set while the clock is low
    task automatic tck(input logic d, input logic ms);
        psi <= d;
        pms <= ms;
        repeat (4) @(posedge clk_i);
        primary_test_clock <= 1'b1;
        repeat (4) @(posedge clk_i);
        primary_test_clock <= 1'b0;
    endtask
    task automatic frame(input logic [9:0] a, input logic ms, input logic glitch);
        logic [11:0] bits;
        bits = {1'b0, a, 1'b1};
        for (int k = 0; k < 12; k++) tck(bits[k], (glitch && k == 6) ? !ms : ms);
        if (a == BOARD) repeat (ACK) tck(1'b0, ms);
    endtask
    task automatic stat(input logic [2:0] exp);
        apb(1'b0, sbrc_pkg::REG_STATUS, 32'h0);
        chk("conn status", {29'h0, exp}, {29'h0, rd[2:0]});
        chk("connect pin", {31'h0, !(exp == sbrc_pkg::CONN_ON || exp == sbrc_pkg::CONN_MCAST)},
            {31'h0, con_n});
    endtask
    initial begin
        n_fail = 0;
        tests_run = 0;
        rst_i = 1'b1;
        primary_test_clock = 1'b0;
        psi = 1'b0;
        pms = 1'b1;
        primary_test_reset_n_n = 1'b1;
        byp_n = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        stat(sbrc_pkg::CONN_RESET);
        apb(1'b0, sbrc_pkg::REG_CTRL, 32'h0);
        chk("ctrl reset", 32'h1, rd);
        apb(1'b1, sbrc_pkg::REG_CTRL, {22'h0, BOARD});
        apb(1'b0, sbrc_pkg::REG_CTRL, 32'h0);
        chk("ctrl", {22'h0, BOARD}, rd);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        for (int k = 0; k < 7; k++) begin
            frame(SEQ_A[k], 1'b1, 1'b0);
            stat(SEQ_C[k]);
        end
        frame(10'h3fe, 1'b1, 1'b0);
        byp_n <= 1'b0;
        psi <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk("bypass connect pin", 32'h0, {31'h0, con_n});
        chk("bypass data", 32'h1, {31'h0, sso});
        frame(BOARD, 1'b1, 1'b0);
        byp_n <= 1'b1;
        repeat (6) @(posedge clk_i);
        stat(sbrc_pkg::CONN_OFF);
        frame(BOARD, 1'b1, 1'b0);
        stat(sbrc_pkg::CONN_ON);
        primary_test_reset_n_n <= 1'b0;
        frame(10'h3fe, 1'b1, 1'b0);
        chk("reset pins", 32'h4, {29'h0, con_n, pso_oe, sso_oe});
        chk("reset mode select", 32'h1, {31'h0, sms});
        chk("reset forward", 32'h0, {31'h0, secondary_test_reset_n_n});
        primary_test_reset_n_n <= 1'b1;
        repeat (6) @(posedge clk_i);
        stat(sbrc_pkg::CONN_RESET);
        byp_n <= 1'b0;
        primary_test_reset_n_n <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk("bypass reset pins", 32'h1, {30'h0, con_n, sms});
        byp_n <= 1'b1;
        primary_test_reset_n_n <= 1'b1;
        repeat (6) @(posedge clk_i);
        // walk the tracked tap from test-logic-reset to pause-dr
        for (int k = 0; k < 6; k++) tck(1'b0, (k == 1) || (k == 4));
        frame(10'h3ff, 1'b0, 1'b0);
        stat(sbrc_pkg::CONN_MCAST);
        frame(BOARD, 1'b0, 1'b1);
        stat(sbrc_pkg::CONN_HARD);
        wrap_up();
    end
endmodule
`default_nettype wire
